// ---- pkg/dqvr_pkg.sv ----
// constants and helpers for the dq reference level mode register
`default_nettype none
package dqvr_pkg;
    // mode register addresses
    localparam logic [5:0] DQVR_MR_ADDR = 6'h0e;
    localparam logic [5:0] DQVR_CTRL_ADDR = 6'h0d;
    // field positions
    localparam int DQVR_CODE_LSB = 0;
    localparam int DQVR_CODE_W = 6;
    localparam int DQVR_RANGE_BIT = 6;
    localparam int DQVR_RESV_BIT = 7;
    localparam int DQVR_ACCESS_SEL_BIT = 6;
    localparam int DQVR_OPERATE_SEL_BIT = 7;
    // values after reset
    localparam logic [7:0] DQVR_RESET_VALUE = 8'h4d;
    localparam logic [5:0] DQVR_RESET_CODE = 6'h0d;
    localparam logic DQVR_RESET_RANGE = 1'b1;
    localparam logic [8:0] DQVR_RESET_TENTHS = 9'h110;
    // highest legal level code
    localparam logic [5:0] DQVR_CODE_MAX = 6'h32;
    // level in tenths of a percent of the io supply
    localparam logic [8:0] DQVR_RANGE0_BASE = 9'h064;
    localparam logic [8:0] DQVR_RANGE1_BASE = 9'h0dc;
    localparam int DQVR_STEP_SHIFT = 2;
    // read data appears this many cycles after the read command
    localparam int DQVR_READ_LATENCY = 1;

    function automatic logic dqvr_code_ok(input logic [7:0] value);
        return value[DQVR_CODE_W-1:DQVR_CODE_LSB] <= DQVR_CODE_MAX;
    endfunction
endpackage
`default_nettype wire

// ---- pkg/dqvr_copy_if.sv ----
// signals between the control logic and the two set point copies
`timescale 1ns/1ps
`default_nettype none
interface dqvr_copy_if;
    logic wr_en;
    logic wr_sel;
    logic [7:0] wr_data;
    logic rd_sel;
    logic [7:0] rd_data;
    logic op_sel;
    logic [7:0] op_data;
    modport store (
        input wr_en, wr_sel, wr_data, rd_sel, op_sel,
        output rd_data, op_data
    );
    modport ctrl (
        output wr_en, wr_sel, wr_data, rd_sel, op_sel,
        input rd_data, op_data
    );
endinterface
`default_nettype wire

// ---- rtl/dqvr_copy_store.sv ----
// two physical copies of the register, one per set point
`timescale 1ns/1ps
`default_nettype none
module dqvr_copy_store
    import dqvr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    dqvr_copy_if.store bus
);
    logic [7:0] copy [2];
    logic [7:0] next_copy [2];

    always_comb begin
        next_copy[0] = copy[0];
        next_copy[1] = copy[1];
        if (bus.wr_en) begin
            next_copy[bus.wr_sel] = bus.wr_data; // R6 R7
            next_copy[bus.wr_sel][DQVR_RESV_BIT] = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            copy[0] <= DQVR_RESET_VALUE; // R15
            copy[1] <= DQVR_RESET_VALUE; // R15
        end else begin
            copy[0] <= next_copy[0]; // R10
            copy[1] <= next_copy[1]; // R10
        end
    end

    assign bus.rd_data = copy[bus.rd_sel]; // R7
    assign bus.op_data = copy[bus.op_sel]; // R8

endmodule // dqvr_copy_store
`default_nettype wire

// ---- rtl/dqvr_level_map.sv ----
// level code and range to tenths of a percent of the io supply
`timescale 1ns/1ps
`default_nettype none
module dqvr_level_map
    import dqvr_pkg::*;
(
    input wire logic [5:0] i_code,
    input wire logic i_range,
    output logic [8:0] o_tenths
);
    logic [8:0] base;

    always_comb begin
        base = i_range ? DQVR_RANGE1_BASE : DQVR_RANGE0_BASE; // R12 R13
        o_tenths = base + ({3'h0, i_code} << DQVR_STEP_SHIFT); // R12 R13
    end

endmodule // dqvr_level_map
`default_nettype wire

// ---- rtl/dqvr_top.sv ----
// dq reference level mode register with two set point copies
// Summary of operation
// [R1] the register answers mode register writes and reads at address 0eh
// [R2] level codes 000000 to 110010 are accepted; other codes are reserved
// [R3] bit 6 picks reference range 0 or 1; range 1 after reset
// [R4] a read of this address puts register bits 7..0 on dq 7..0
// [R5] reserved bit 7 and unused dq lines read as zero
// [R6] a level write goes to set point 0 or 1 per access select
// [R7] two copies exist; writes and reads reach only the access-selected one
// [R8] only the copy picked by operate select drives the applied level
// [R9] the inactive copy is ignored and may be rewritten freely
// [R10] stored values hold until overwritten or reset to default
// [R11] the controller sends range and level together in one write
// [R12] range 0: 10.0 percent at code 0, 0.4 percent per step, 30.0 top
// [R13] range 1: 22.0 percent at code 0 up to 42.0; default 27.2 percent
// [R14] access and operate select come from the control register at 0dh
// [R15] after reset both copies hold 4dh: range 1, code 001101
`timescale 1ns/1ps
`default_nettype none
module dqvr_top
    import dqvr_pkg::*;
#(
    parameter int DQ_WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_mrw,
    input wire logic i_mrr,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_access_sel,
    input wire logic i_operate_sel,
    output logic [DQ_WIDTH-1:0] o_dq,
    output logic o_dq_valid,
    output logic o_write_refused,
    output logic [5:0] o_level_code,
    output logic o_range_sel,
    output logic [8:0] o_level_tenths
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration check

    if (DQ_WIDTH < 8) begin : g_bad_width
        $error("dq width must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // copies and level map

    dqvr_copy_if bus ();

    dqvr_copy_store u_store (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .bus(bus)
    );

    logic [8:0] map_tenths;

    dqvr_level_map u_map (
        .i_code(bus.op_data[DQVR_CODE_W-1:DQVR_CODE_LSB]),
        .i_range(bus.op_data[DQVR_RANGE_BIT]),
        .o_tenths(map_tenths)
    );

    ////////////////////////////////////////////////////////////////////////
    // command decode

    logic addr_hit;
    logic write_ok;
    logic write_bad;
    logic read_hit;

    always_comb begin
        addr_hit = i_addr == DQVR_MR_ADDR; // R1
        write_ok = i_mrw && addr_hit && dqvr_code_ok(i_wdata); // R2
        write_bad = i_mrw && addr_hit && !dqvr_code_ok(i_wdata); // R2
        read_hit = i_mrr && addr_hit; // R1
    end

    // select bits held by the control register outside this block
    assign bus.wr_en = write_ok; // R6
    assign bus.wr_sel = i_access_sel; // R6 R14
    assign bus.wr_data = i_wdata; // R11
    assign bus.rd_sel = i_access_sel; // R7 R14
    assign bus.op_sel = i_operate_sel; // R8 R14

    ////////////////////////////////////////////////////////////////////////
    // read return and refusal flag

    logic [DQ_WIDTH-1:0] next_dq;
    logic next_dq_valid;
    logic next_write_refused;

    always_comb begin
        next_dq = '0; // R5
        next_dq_valid = read_hit;
        next_write_refused = write_bad; // R2
        if (read_hit) begin
            next_dq[DQVR_RANGE_BIT:0] = bus.rd_data[DQVR_RANGE_BIT:0]; // R4
            next_dq[DQVR_RESV_BIT] = 1'b0; // R5
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dq <= '0;
            o_dq_valid <= 1'b0;
            o_write_refused <= 1'b0;
        end else begin
            o_dq <= next_dq;
            o_dq_valid <= next_dq_valid;
            o_write_refused <= next_write_refused;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // applied level from the operating copy

    logic [5:0] next_level_code;
    logic next_range_sel;
    logic [8:0] next_level_tenths;

    always_comb begin
        next_level_code = bus.op_data[DQVR_CODE_W-1:DQVR_CODE_LSB]; // R8 R9
        next_range_sel = bus.op_data[DQVR_RANGE_BIT]; // R3 R8
        next_level_tenths = map_tenths; // R12 R13
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_level_code <= DQVR_RESET_CODE; // R15
            o_range_sel <= DQVR_RESET_RANGE; // R3
            o_level_tenths <= DQVR_RESET_TENTHS; // R13
        end else begin
            o_level_code <= next_level_code;
            o_range_sel <= next_range_sel;
            o_level_tenths <= next_level_tenths;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    // first cycle after reset marker
    logic seen_clock;
    logic next_seen_clock;

    always_comb begin
        next_seen_clock = 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seen_clock <= 1'b0;
        end else begin
            seen_clock <= next_seen_clock;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    map_addr_a: assert property ( // R1
        i_mrr && !addr_hit |=> !o_dq_valid
    ) else $error("read of another address answered");

    code_refuse_a: assert property ( // R2
        write_bad |=> o_write_refused
    ) else $error("reserved level code not flagged");

    refuse_only_a: assert property ( // R2
        !write_bad |=> !o_write_refused
    ) else $error("refusal flag raised without a reserved code");

    refuse_whole_a: assert property ( // R2
        write_bad && i_access_sel == i_operate_sel ##1 $stable(i_operate_sel)
        |-> $stable(bus.op_data)
    ) else $error("refused write reached the operating copy");

    bad_code_keep_a: assert property ( // R2
        write_bad && $stable(i_access_sel) ##1 $stable(i_access_sel)
        |-> $stable(bus.rd_data) && o_write_refused
    ) else $error("reserved level code was stored");

    range_store_a: assert property ( // R3
        write_ok ##1 $stable(i_access_sel)
        |-> bus.rd_data[DQVR_RANGE_BIT] == $past(i_wdata[DQVR_RANGE_BIT])
    ) else $error("range bit not stored");

    read_data_a: assert property ( // R4
        read_hit |=> o_dq_valid
            && o_dq[DQVR_RANGE_BIT:0] == $past(bus.rd_data[DQVR_RANGE_BIT:0])
    ) else $error("read data does not match selected copy");

    read_zero_a: assert property ( // R5
        o_dq_valid |-> o_dq[DQ_WIDTH-1:DQVR_RESV_BIT] == '0
    ) else $error("reserved or unused dq line not zero");

    write_sel_a: assert property ( // R6
        write_ok ##1 $stable(i_access_sel)
        |-> bus.rd_data[DQVR_CODE_W-1:0] == $past(i_wdata[DQVR_CODE_W-1:0])
    ) else $error("level code not written to selected copy");

    other_copy_a: assert property ( // R7
        write_ok && i_operate_sel != i_access_sel ##1
        $stable(i_operate_sel) ##1 $stable(i_operate_sel)
        |-> $stable(o_level_code) && $stable(o_range_sel)
    ) else $error("write reached the unselected copy");

    op_apply_a: assert property ( // R8
        ##1 1'b1 |-> o_level_code == $past(bus.op_data[DQVR_CODE_W-1:0])
            && o_range_sel == $past(bus.op_data[DQVR_RANGE_BIT])
    ) else $error("applied level not from operating copy");

    inactive_a: assert property ( // R9
        (!write_ok || i_access_sel != i_operate_sel)
        ##1 $stable(i_operate_sel) ##1 $stable(i_operate_sel)
        |-> $stable(o_level_tenths)
    ) else $error("applied level moved without cause");

    hold_a: assert property ( // R10
        !write_ok ##1 $stable(i_access_sel) |-> $stable(bus.rd_data)
    ) else $error("stored value changed without a write");

    level_map_a: assert property ( // R12
        ##1 1'b1 |-> o_level_tenths == ($past(bus.op_data[DQVR_RANGE_BIT])
            ? DQVR_RANGE1_BASE : DQVR_RANGE0_BASE)
            + {1'b0, $past(bus.op_data[DQVR_CODE_W-1:0]), 2'b00}
    ) else $error("applied level in tenths is wrong");

    reset_value_a: assert property ( // R15
        !seen_clock |-> bus.rd_data == DQVR_RESET_VALUE
            && bus.op_data == DQVR_RESET_VALUE
    ) else $error("copies not at default after reset");

    reset_level_a: assert property ( // R13
        !seen_clock |-> o_level_tenths == DQVR_RESET_TENTHS && o_range_sel
    ) else $error("default level is not 27.2 percent");

    ////////////////////////////////////////////////////////////////////////
    // applied level, storage and read return limits

    reset_code_a: assert property ( // R15
        !seen_clock |-> o_level_code == DQVR_RESET_CODE
    ) else $error("default level code missing after reset");

    code_limit_a: assert property ( // R2
        o_level_code <= DQVR_CODE_MAX
    ) else $error("applied level code is reserved");

    level_bounds_a: assert property ( // R12 R13
        o_level_tenths >= DQVR_RANGE0_BASE
            && o_level_tenths <= DQVR_RANGE1_BASE + ({3'h0, DQVR_CODE_MAX} << DQVR_STEP_SHIFT)
    ) else $error("applied level outside both ranges");

    resv_store_a: assert property ( // R5
        bus.rd_data[DQVR_RESV_BIT] == 1'b0 && bus.op_data[DQVR_RESV_BIT] == 1'b0
    ) else $error("reserved bit stored as one");

    read_quiet_a: assert property ( // R5
        !read_hit |=> !o_dq_valid && o_dq == '0
    ) else $error("dq lines driven without a read");

    read_once_a: assert property ( // R4
        o_dq_valid |-> $past(read_hit)
    ) else $error("read data valid without a read");

    isolate_op_a: assert property ( // R7 R9
        write_ok && i_operate_sel != i_access_sel ##1 $stable(i_operate_sel)
        |-> $stable(bus.op_data)
    ) else $error("write to the access copy reached the operating copy");

    follow_op_a: assert property ( // R6 R8
        write_ok && i_operate_sel == i_access_sel ##1 $stable(i_operate_sel)
        |-> bus.op_data[DQVR_RANGE_BIT:0] == $past(i_wdata[DQVR_RANGE_BIT:0])
    ) else $error("write to the operating copy not applied");

    ////////////////////////////////////////////////////////////////////////
    // scenario covers

    same_cycle_c: cover property (
        write_ok && read_hit
    );

    read_write_c: cover property (
        write_ok ##1 read_hit ##1 o_dq_valid
    );

    switch_op_c: cover property (
        write_ok && i_access_sel != i_operate_sel ##[1:20] $changed(i_operate_sel)
    );

    refuse_c: cover property (
        write_bad ##1 o_write_refused
    );

    range0_c: cover property (
        !o_range_sel && o_level_code == DQVR_CODE_MAX
    );

endmodule // dqvr_top
`default_nettype wire

// ---- testbench/dqvr_ctrl_model.sv ----
// controller model issuing mode register writes and reads
`timescale 1ns/1ps
`default_nettype none
module dqvr_ctrl_model (
    input wire logic i_clock,
    output logic o_mrw,
    output logic o_mrr,
    output logic [5:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_access_sel,
    output logic o_operate_sel
);
    initial begin
        o_mrw = 1'b0;
        o_mrr = 1'b0;
        o_addr = 6'h3f;
        o_wdata = 8'hff;
        o_access_sel = 1'b0;
        o_operate_sel = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one command, held for one edge; on release the strobes drop, address and data flip
    task automatic cmd(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_mrw = w;
        o_mrr = r;
        o_addr = a;
        o_wdata = d;
        @(negedge i_clock);
        o_mrw = 1'b0;
        o_mrr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic sel(input logic acc, input logic opr);
        @(negedge i_clock);
        o_access_sel = acc;
        o_operate_sel = opr;
    endtask
endmodule // dqvr_ctrl_model
`default_nettype wire

// ---- testbench/dqvr_top_tb_top.sv ----
// self-checking bench for the dq reference level register
`timescale 1ns/1ps
`default_nettype none
module dqvr_top_tb_top;
    import dqvr_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic mrw, mrr, acc, opr, dq_valid, refused, range_sel;
    logic [5:0] addr, code;
    logic [7:0] wdata;
    logic [15:0] dq;
    logic [8:0] tenths;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    dqvr_ctrl_model ctrl (.i_clock(clock), .o_mrw(mrw), .o_mrr(mrr), .o_addr(addr),
        .o_wdata(wdata), .o_access_sel(acc), .o_operate_sel(opr));
    dqvr_top DUT (.i_clock(clock), .i_rst_n(rst_n), .i_mrw(mrw), .i_mrr(mrr), .i_addr(addr),
        .i_wdata(wdata), .i_access_sel(acc), .i_operate_sel(opr), .o_dq(dq),
        .o_dq_valid(dq_valid), .o_write_refused(refused), .o_level_code(code),
        .o_range_sel(range_sel), .o_level_tenths(tenths));
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            conclude;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // applied level check one edge after the copy settles, tenths = base + 4 per step
    task automatic ap(input logic [5:0] c, input logic r);
        logic [8:0] t;
        @(negedge clock);
        t = (r ? DQVR_RANGE1_BASE : DQVR_RANGE0_BASE) + {1'b0, c, 2'b00};
        chk({10'h000, code}, {10'h000, c});
        chk({15'h0000, range_sel}, {15'h0000, r});
        chk({7'h00, tenths}, {7'h00, t});
    endtask
    task automatic rd(input logic a, input logic [7:0] e);
        ctrl.sel(a, opr);
        ctrl.cmd(1'b0, 1'b1, DQVR_MR_ADDR, 8'h00);
        chk({15'h0000, dq_valid}, 16'h0001);
        chk(dq, {8'h00, e});
        @(negedge clock);
        chk({15'h0000, dq_valid}, 16'h0000);
        chk(dq, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_state;
        ap(DQVR_RESET_CODE, DQVR_RESET_RANGE);
        rd(1'b0, DQVR_RESET_VALUE);
        rd(1'b1, DQVR_RESET_VALUE);
    endtask
    task automatic t_setpoints;
        ctrl.sel(1'b0, 1'b0);
        ctrl.cmd(1'b1, 1'b0, DQVR_MR_ADDR, 8'h32);
        ap(6'h32, 1'b0);
        ctrl.sel(1'b1, 1'b0);
        ctrl.cmd(1'b1, 1'b0, DQVR_MR_ADDR, 8'hc0);
        ap(6'h32, 1'b0);
        rd(1'b1, 8'h40);
        rd(1'b0, 8'h32);
        ctrl.sel(1'b1, 1'b1);
        @(negedge clock);
        ap(6'h00, 1'b1);
        ctrl.cmd(1'b1, 1'b0, DQVR_MR_ADDR, 8'h72);
        ap(6'h32, 1'b1);
    endtask
    task automatic t_refused;
        ctrl.cmd(1'b1, 1'b0, DQVR_MR_ADDR, 8'h33);
        chk({15'h0000, refused}, 16'h0001);
        @(negedge clock);
        chk({15'h0000, refused}, 16'h0000);
        ap(6'h32, 1'b1);
        rd(1'b1, 8'h72);
    endtask
    task automatic t_other_addr;
        ctrl.cmd(1'b1, 1'b0, DQVR_CTRL_ADDR, 8'h3f);
        chk({15'h0000, refused}, 16'h0000);
        ctrl.cmd(1'b0, 1'b1, 6'h0f, 8'h00);
        chk({15'h0000, dq_valid}, 16'h0000);
        rd(1'b1, 8'h72);
    endtask
    task automatic t_same_cycle;
        ctrl.cmd(1'b1, 1'b1, DQVR_MR_ADDR, 8'h05);
        chk(dq, 16'h0072);
        ap(6'h05, 1'b0);
    endtask
    task automatic t_reset_again;
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        ctrl.sel(1'b0, 1'b0);
        t_reset_state;
    endtask
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        t_reset_state;
        t_setpoints;
        t_refused;
        t_other_addr;
        t_same_cycle;
        t_reset_again;
        conclude;
    end
endmodule // dqvr_top_tb_top
`default_nettype wire
